// ===== verif/dmcr_host.sv
// host side of the four-wire control port, word by word
// assumes the device samples these lines on its own clock
module dmcr_host (
	input  wire logic clk_i,
	input  wire logic dout_i,
	input  wire logic dout_oe_i,
	output logic      sel_n_o,
	output logic      sclk_o,
	output logic      din_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// -----------------------------------------------
	// idle levels
	// -----------------------------------------------
	initial begin
		sel_n_o = 1'b1;
		sclk_o  = 1'b0;
		din_o   = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// shift clock stands still low outside frames
	task automatic frame(input logic on);
		tick(2);
		sel_n_o = !on;
		din_o   = ~din_o;
	endtask

	// -----------------------------------------------
	// one word, msb first; n below 16 aborts it early
	// -----------------------------------------------
	task automatic word(input logic [15:0] w, input int n,
		output logic [7:0] rd, output logic oe);
		rd = 8'h00;
		oe = 1'b0;
		for (int i = 15; i >= 16 - n; i--) begin
			tick(2);
			sclk_o = 1'b0;
			din_o  = w[i];
			if (i < 8)
				rd[i] = dout_i;
			if (i == 7)
				oe = dout_oe_i;
			tick(2);
			sclk_o = 1'b1;
		end
		tick(2);
		sclk_o = 1'b0;
	endtask
endmodule

// ===== verif/tb_top.sv
// self-checking bench for the mode-control register bank
// assumes the host model drives the control port
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic       clk = 1'b0;
	logic       rst_n;
	logic       tck;
	logic       rlow;
	logic [7:0] zin;
	logic       sel_n;
	logic       sclk;
	logic       din;
	logic       dout;
	logic       oe;
	logic       sck;
	logic       filt;
	logic       pinv;
	logic       dmen;
	logic       allf;
	logic [2:0] lay;
	logic [1:0] drate, hif;
	logic [7:0] osr;
	logic [5:0] pins;
	int         num_errors = 0;
	int         num_checks = 0;
	logic [31:0] seed = 32'h7b17;
	logic [7:0] m [4];
	int         zc [8];

	always #4 clk = ~clk;

	dmcr_top dut_u (.CLOCK_I(clk), .RESETN_I(rst_n), .CTRL_SEL_N_I(sel_n),
		.CTRL_CLK_I(sclk), .CTRL_DIN_I(din), .CTRL_DOUT_O(dout),
		.CTRL_DOUT_OE_O(oe), .SAMPLE_TICK_I(tck), .CH_DATA_ZERO_I(zin),
		.CLK_RATIO_LOW_I(rlow), .SYSCLK_OUT_O(sck),
		.AUDIO_WORD_LAYOUT_O(lay), .FILTER_SLOW_O(filt),
		.PHASE_INVERT_O(pinv), .DEEMPH_RATE_SELECT_O(drate),
		.DEEMPH_ENABLE_O(dmen), .OVERSAMPLE_RATIO_O(osr),
		.SHARED_PIN_O(pins), .SILENCE_FLAG_HI_O(hif),
		.SILENCE_FLAG_ALL_O(allf));

	dmcr_host host_u (.clk_i(clk), .dout_i(dout), .dout_oe_i(oe),
		.sel_n_o(sel_n), .sclk_o(sclk), .din_o(din));

	// -----------------------------------------------
	// helpers and reference model
	// -----------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [7:0] mv(input int i);
		return (i >= 9 && i <= 12) ? m[i-9] : 8'h00;
	endfunction

	function automatic logic [7:0] det();
		logic [7:0] r;
		for (int i = 0; i < 8; i++)
			r[i] = zc[i] >= 1024;
		return r;
	endfunction

	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic wr(input int i, input logic [7:0] v);
		logic [7:0] r;
		logic o;
		host_u.frame(1'b1);
		host_u.word({1'b0, 7'(i), v}, 16, r, o);
		host_u.frame(1'b0);
		if (i == 9)
			m[0] = v & 8'h3f;
		else if (i == 10)
			m[1] = v & 8'h7f;
		else if (i == 11 || i == 12)
			m[i-9] = v;
	endtask

	task automatic rdw(input logic [7:0] e, input logic eo);
		logic [7:0] r;
		logic o;
		host_u.word(16'h8000, 16, r, o);
		chk("read_oe", 8'(eo), 8'(o));
		if (eo)
			chk("read_data", e, r);
	endtask

	task automatic rd_sel(input int i);
		wr(11, 8'(i));
		host_u.frame(1'b1);
		rdw(mv(i), 1'b1);
		host_u.frame(1'b0);
	endtask

	task automatic check_outs();
		logic [7:0] f;
		logic [7:0] o;
		repeat (2) @(posedge clk);
		#1;
		f = det() ^ {8{m[1][6]}};
		o = !m[3][7] ? (rlow ? 8'h20 : 8'h40) : (rlow ? 8'h40 : 8'h80);
		chk("layout", 8'(m[0][2:0]), 8'(lay));
		chk("filter", 8'(m[0][5]), 8'(filt));
		chk("phase", 8'(m[1][5]), 8'(pinv));
		chk("drate", 8'(m[1][4:3]), 8'(drate));
		chk("deemph", 8'(|m[1][2:0]), 8'(dmen));
		chk("osr", o, osr);
		chk("pins", 8'(m[3][6] ? m[3][5:0] : f[5:0]), 8'(pins));
		chk("flag_hi", 8'(f[7:6]), 8'(hif));
		chk("flag_all", 8'((&det()) ^ m[1][6]), 8'(allf));
	endtask

	// zero-tick pulses; model counters follow each pulse
	task automatic zt(input logic [7:0] msk, input int n);
		repeat (n) begin
			@(posedge clk);
			#1 tck = 1'b1;
			zin = msk;
			@(posedge clk);
			#1 tck = 1'b0;
			for (int i = 0; i < 8; i++)
				zc[i] = msk[i] ? zc[i] + 1 : 0;
		end
	endtask

	task automatic clk_chk();
		logic p;
		@(posedge clk);
		#2 p = sck;
		repeat (3) begin
			@(posedge clk);
			#2;
			if (m[0][3])
				chk("sck_off", 8'h00, 8'(sck));
			else if (m[0][4])
				chk("sck_half", 8'(!p), 8'(sck));
			else begin
				chk("sck_hi", 8'h01, 8'(sck));
				@(negedge clk);
				#2 chk("sck_lo", 8'h00, 8'(sck));
			end
			p = sck;
		end
	endtask

	// -----------------------------------------------
	// main sequence
	// -----------------------------------------------
	initial begin
		#400000;
		num_errors++;
		end_sim();
	end

	initial begin
		logic [7:0] v;
		logic o;
		int i;
		rst_n = 1'b0;
		tck = 1'b0;
		rlow = 1'b0;
		zin = 8'h00;
		m = '{8'h00, 8'h00, 8'h01, 8'h00};
		zc = '{default: 0};
		repeat (6) @(posedge clk);
		#1 rst_n = 1'b1;
		check_outs();
		clk_chk();
		host_u.frame(1'b1);
		rdw(8'h00, 1'b1);
		host_u.frame(1'b0);
		for (int k = 9; k <= 13; k++)
			rd_sel(k);
		for (int k = 0; k < 6; k++) begin
			wr(9, 8'(k));
			check_outs();
		end
		for (int k = 0; k < 8; k++) begin
			wr(10, 8'(k | ((k % 3) << 3)));
			check_outs();
		end
		repeat (40) begin
			i = 9 + rnd() % 5;
			v = 8'(rnd());
			if (i == 9 && v[2:1] == 2'b11)
				v[2] = 1'b0;
			if (i == 10 && v[4:3] == 2'b11)
				v[4] = 1'b0;
			rlow = 1'(rnd());
			wr(i, v);
			zt(8'(rnd()), 1);
			check_outs();
		end
		for (int k = 9; k <= 13; k++)
			rd_sel(k);
		host_u.frame(1'b1);
		host_u.word({1'b0, 7'h0c, ~m[3]}, 10, v, o);
		host_u.frame(1'b0);
		check_outs(); // aborted word leaves registers alone
		wr(11, 8'h8c);
		host_u.frame(1'b1);
		for (int k = 1; k <= 13; k++)
			rdw(mv(k), k <= 12);
		host_u.frame(1'b0);
		for (int k = 0; k < 4; k++) begin
			wr(9, 8'(k * 8));
			clk_chk();
		end
		wr(12, 8'h15);
		wr(10, 8'h00);
		zt(8'h00, 1);
		zt(8'hff, 1023);
		check_outs();
		zt(8'hff, 1);
		check_outs();
		wr(10, 8'h40);
		check_outs();
		zt(8'hfb, 1);
		check_outs();
		wr(12, 8'h6a);
		check_outs();
		rlow = 1'b1;
		wr(12, 8'h80);
		check_outs();
		end_sim();
	end
endmodule

// ===== verilog/dmcr_pkg.sv
// constants for the dac mode-control register bank
// assumes a 16-bit serial control word, msb first
package dmcr_pkg;

	// -----------------------------------------------
	// register indexes
	// -----------------------------------------------
	localparam logic [6:0] IDX_FMT      = 7'h09;
	localparam logic [6:0] IDX_DEEMPH   = 7'h0a;
	localparam logic [6:0] IDX_READBACK = 7'h0b;
	localparam logic [6:0] IDX_MODGPIO  = 7'h0c;
	localparam logic [6:0] IDX_FIRST    = 7'h01;

	// -----------------------------------------------
	// control word layout
	// -----------------------------------------------
	localparam int         RW_BIT    = 15;
	localparam int         IDX_HI    = 14;
	localparam int         IDX_LO    = 8;
	localparam int         RW_IN_HDR = 6;
	localparam logic [3:0] CNT_HDR   = 4'h7;
	localparam logic [3:0] CNT_LAST  = 4'hf;

	// -----------------------------------------------
	// reset values and writable masks
	// -----------------------------------------------
	localparam logic [7:0] RST_FMT      = 8'h00;
	localparam logic [7:0] RST_DEEMPH   = 8'h00;
	localparam logic [7:0] RST_READBACK = 8'h01;
	localparam logic [7:0] RST_MODGPIO  = 8'h00;
	localparam logic [7:0] MSK_FMT      = 8'h3f;
	localparam logic [7:0] MSK_DEEMPH   = 8'h7f;
	localparam logic [7:0] MSK_FULL     = 8'hff;
	localparam logic [7:0] RD_NONE      = 8'h00;

	// -----------------------------------------------
	// field positions
	// -----------------------------------------------
	localparam int FLT_POS  = 5;
	localparam int SYSCLK_OUT_HALF_RATE_POS = 4;
	localparam int SYSCLK_OUT_ENABLE_POS = 3;
	localparam int FMT_HI   = 2;
	localparam int FMT_LO   = 0;
	localparam int FLAG_POLARITY_POS = 6;
	localparam int PHASE_INVERT_POS = 5;
	localparam int DMF_HI   = 4;
	localparam int DMF_LO   = 3;
	localparam int DMC_HI   = 2;
	localparam int DMC_LO   = 0;
	localparam int INC_POS  = 7;
	localparam int REG_HI   = 6;
	localparam int REG_LO   = 0;
	localparam int OVER_POS = 7;
	localparam int USER_OUTPUT_ENABLE_POS = 6;
	localparam int GPO_HI   = 5;
	localparam int GPO_LO   = 0;

	// -----------------------------------------------
	// zero detect and oversampling
	// -----------------------------------------------
	localparam int          ZCNT_W     = 11;
	localparam logic [10:0] ZERO_LIMIT = 11'h400;
	localparam logic [7:0]  OSR_32     = 8'h20;
	localparam logic [7:0]  OSR_64     = 8'h40;
	localparam logic [7:0]  OSR_128    = 8'h80;

endpackage

// ===== verilog/dmcr_top.sv
// mode-control registers of an eight-channel dac
// serial control port inputs are synchronous to CLOCK_I,
// sampled once per clock; one tick per audio sample period
// Notes on behaviour
// - clock output runs while enable bit is 0, held low when 1
// - enabled clock output is full or half rate per select bit
// - three-bit layout field picks audio format, 110/111 reserved
// - flag polarity 0 gives high flags on zero, 1 gives low
// - phase invert bit 1 inverts output polarity, 0 normal
// - de-emphasis rate: 00 44.1k, 01 48k, 10 32k, 11 reserved
// - any of three de-emphasis bits set enables it everywhere
// - sequential read bit enables auto-increment reads when 1
// - read index field names register for a single read
// - auto-increment read stops after register named by index
// - high clock ratios: rate bit picks 64x or 128x
// - 128 or 192 clock ratio: rate bit picks 32x or 64x
// - user enable 0: six shared pins carry channel flags 1..6
// - user enable 1: shared pins drive user bits, reset 0
// - word msb 0 requests write, 1 requests read
// - channel zero after 1024 consecutive zero sample periods
// - combined flag only when all eight channels are zero
// - half-rate bit 0 passes input clock, 1 halves it
module dmcr_top (
	input  wire logic       CLOCK_I,
	input  wire logic       RESETN_I,
	input  wire logic       CTRL_SEL_N_I,
	input  wire logic       CTRL_CLK_I,
	input  wire logic       CTRL_DIN_I,
	output logic            CTRL_DOUT_O,
	output logic            CTRL_DOUT_OE_O,
	input  wire logic       SAMPLE_TICK_I,
	input  wire logic [7:0] CH_DATA_ZERO_I,
	input  wire logic       CLK_RATIO_LOW_I,
	output logic            SYSCLK_OUT_O,
	output logic [2:0]      AUDIO_WORD_LAYOUT_O,
	output logic            FILTER_SLOW_O,
	output logic            PHASE_INVERT_O,
	output logic [1:0]      DEEMPH_RATE_SELECT_O,
	output logic            DEEMPH_ENABLE_O,
	output logic [7:0]      OVERSAMPLE_RATIO_O,
	output logic [5:0]      SHARED_PIN_O,
	output logic [1:0]      SILENCE_FLAG_HI_O,
	output logic            SILENCE_FLAG_ALL_O
);

	// -----------------------------------------------
	// serial control port
	// -----------------------------------------------
	logic        mc_prev_ff;
	logic [15:0] shift_ff;
	logic [3:0]  bit_cnt_ff;
	logic        mc_rise;
	logic [15:0] word;
	logic        wr_commit;
	logic        rd_start;

	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I)
			mc_prev_ff <= 1'b0;
		else
			mc_prev_ff <= CTRL_CLK_I;
	end

	assign mc_rise = CTRL_CLK_I & ~mc_prev_ff & ~CTRL_SEL_N_I;
	assign word    = {shift_ff[14:0], CTRL_DIN_I};

	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I)
			shift_ff <= 16'h0000;
		else if (mc_rise)
			shift_ff <= word;
	end

	// a dropped select aborts a partial word
	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I)
			bit_cnt_ff <= 4'h0;
		else if (CTRL_SEL_N_I)
			bit_cnt_ff <= 4'h0;
		else if (mc_rise)
			bit_cnt_ff <= bit_cnt_ff + 4'h1;
	end

	assign wr_commit = mc_rise && (bit_cnt_ff == dmcr_pkg::CNT_LAST)
		&& !word[dmcr_pkg::RW_BIT];
	assign rd_start  = mc_rise && (bit_cnt_ff == dmcr_pkg::CNT_HDR)
		&& shift_ff[dmcr_pkg::RW_IN_HDR];

	// -----------------------------------------------
	// registers
	// -----------------------------------------------
	logic [7:0] fmt_ff;
	logic [7:0] deemph_ff;
	logic [7:0] readback_ff;
	logic [7:0] modgpio_ff;
	logic [6:0] wr_idx;

	assign wr_idx = word[dmcr_pkg::IDX_HI:dmcr_pkg::IDX_LO];

	// reserved bits are masked so they always read zero
	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I)
			fmt_ff <= dmcr_pkg::RST_FMT;
		else if (wr_commit && wr_idx == dmcr_pkg::IDX_FMT)
			fmt_ff <= word[7:0] & dmcr_pkg::MSK_FMT;
	end

	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I)
			deemph_ff <= dmcr_pkg::RST_DEEMPH;
		else if (wr_commit && wr_idx == dmcr_pkg::IDX_DEEMPH)
			deemph_ff <= word[7:0] & dmcr_pkg::MSK_DEEMPH;
	end

	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I)
			readback_ff <= dmcr_pkg::RST_READBACK;
		else if (wr_commit && wr_idx == dmcr_pkg::IDX_READBACK)
			readback_ff <= word[7:0] & dmcr_pkg::MSK_FULL;
	end

	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I)
			modgpio_ff <= dmcr_pkg::RST_MODGPIO;
		else if (wr_commit && wr_idx == dmcr_pkg::IDX_MODGPIO)
			modgpio_ff <= word[7:0] & dmcr_pkg::MSK_FULL;
	end

	logic       sysclk_out_enable;
	logic       sysclk_out_half_rate;
	logic       flag_polarity;
	logic       inc;
	logic [6:0] read_index;
	logic       over;
	logic       user_output_enable;
	logic [5:0] gpo;

	assign sysclk_out_enable       = fmt_ff[dmcr_pkg::SYSCLK_OUT_ENABLE_POS];
	assign sysclk_out_half_rate       = fmt_ff[dmcr_pkg::SYSCLK_OUT_HALF_RATE_POS];
	assign flag_polarity       = deemph_ff[dmcr_pkg::FLAG_POLARITY_POS];
	assign inc        = readback_ff[dmcr_pkg::INC_POS];
	assign read_index = readback_ff[dmcr_pkg::REG_HI:dmcr_pkg::REG_LO];
	assign over       = modgpio_ff[dmcr_pkg::OVER_POS];
	assign user_output_enable       = modgpio_ff[dmcr_pkg::USER_OUTPUT_ENABLE_POS];
	assign gpo        = modgpio_ff[dmcr_pkg::GPO_HI:dmcr_pkg::GPO_LO];

	// -----------------------------------------------
	// read-back
	// -----------------------------------------------
	logic [6:0] rd_ptr_ff;
	logic       rd_done_ff;
	logic [7:0] tx_ff;
	logic       oe_ff;
	logic [6:0] rd_sel;
	logic       rd_active;
	logic [7:0] rd_data;

	// other indexes live outside this bank and read as zero
	always_comb begin
		unique case (rd_sel)
			dmcr_pkg::IDX_FMT:      rd_data = fmt_ff;
			dmcr_pkg::IDX_DEEMPH:   rd_data = deemph_ff;
			dmcr_pkg::IDX_READBACK: rd_data = readback_ff;
			dmcr_pkg::IDX_MODGPIO:  rd_data = modgpio_ff;
			default:                rd_data = dmcr_pkg::RD_NONE;
		endcase
	end

	assign rd_sel    = inc ? rd_ptr_ff : read_index;
	assign rd_active = rd_start && !(inc && rd_done_ff);

	// with inc set, each read word in one frame returns the next register
	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I)
			rd_ptr_ff <= dmcr_pkg::IDX_FIRST;
		else if (CTRL_SEL_N_I)
			rd_ptr_ff <= dmcr_pkg::IDX_FIRST;
		else if (rd_active && inc)
			rd_ptr_ff <= rd_ptr_ff + 7'h01;
	end

	// >= also ends a sequence whose last index is below the first
	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I)
			rd_done_ff <= 1'b0;
		else if (CTRL_SEL_N_I)
			rd_done_ff <= 1'b0;
		else if (rd_active && inc && rd_ptr_ff >= read_index)
			rd_done_ff <= 1'b1;
	end

	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I)
			tx_ff <= 8'h00;
		else if (rd_active)
			tx_ff <= rd_data;
		else if (mc_rise)
			tx_ff <= {tx_ff[6:0], 1'b0};
	end

	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I)
			oe_ff <= 1'b0;
		else if (CTRL_SEL_N_I)
			oe_ff <= 1'b0;
		else if (rd_active)
			oe_ff <= 1'b1;
		else if (mc_rise && bit_cnt_ff == dmcr_pkg::CNT_LAST)
			oe_ff <= 1'b0;
	end

	assign CTRL_DOUT_O    = tx_ff[7];
	assign CTRL_DOUT_OE_O = oe_ff;

	// -----------------------------------------------
	// system clock output
	// -----------------------------------------------
	logic div_ff;

	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I)
			div_ff <= 1'b0;
		else
			div_ff <= ~div_ff;
	end

	// full rate passes the clock itself; a gated clock, kept
	// out of any logic inside the block
	assign SYSCLK_OUT_O = !sysclk_out_enable && (sysclk_out_half_rate ? div_ff : CLOCK_I);

	// -----------------------------------------------
	// mode outputs
	// -----------------------------------------------
	assign AUDIO_WORD_LAYOUT_O  =
		fmt_ff[dmcr_pkg::FMT_HI:dmcr_pkg::FMT_LO];
	assign FILTER_SLOW_O        = fmt_ff[dmcr_pkg::FLT_POS];
	assign PHASE_INVERT_O       = deemph_ff[dmcr_pkg::PHASE_INVERT_POS];
	assign DEEMPH_RATE_SELECT_O =
		deemph_ff[dmcr_pkg::DMF_HI:dmcr_pkg::DMF_LO];
	assign DEEMPH_ENABLE_O      =
		|deemph_ff[dmcr_pkg::DMC_HI:dmcr_pkg::DMC_LO];

	// low ratios run the modulator one octave slower
	always_comb begin
		if (CLK_RATIO_LOW_I)
			OVERSAMPLE_RATIO_O = over ? dmcr_pkg::OSR_64
				: dmcr_pkg::OSR_32;
		else
			OVERSAMPLE_RATIO_O = over ? dmcr_pkg::OSR_128
				: dmcr_pkg::OSR_64;
	end

	// -----------------------------------------------
	// zero detect and flags
	// -----------------------------------------------
	logic [dmcr_pkg::ZCNT_W-1:0] zcnt_ff [8];
	logic [7:0]                  det;
	logic [7:0]                  flag;

	for (genvar ch = 0; ch < 8; ch++) begin : g_zero
		always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
			if (!RESETN_I)
				zcnt_ff[ch] <= '0;
			else if (SAMPLE_TICK_I && !CH_DATA_ZERO_I[ch])
				zcnt_ff[ch] <= '0;
			else if (SAMPLE_TICK_I && !det[ch])
				zcnt_ff[ch] <= zcnt_ff[ch] + 11'h001;
		end
		assign det[ch] = (zcnt_ff[ch] == dmcr_pkg::ZERO_LIMIT);
	end

	assign flag               = det ^ {8{flag_polarity}};
	assign SILENCE_FLAG_HI_O  = flag[7:6];
	assign SILENCE_FLAG_ALL_O = (&det) ^ flag_polarity;
	assign SHARED_PIN_O       = user_output_enable ? gpo : flag[5:0];

	// -----------------------------------------------
	// assertions
	// -----------------------------------------------
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!RESETN_I);

	property p_clk_off;
		sysclk_out_enable |-> !SYSCLK_OUT_O;
	endproperty
	a_clk_off: assert property (p_clk_off)
		else $error("clock output not low while disabled");

	property p_half_rate;
		!sysclk_out_enable && sysclk_out_half_rate && $past(!sysclk_out_enable && sysclk_out_half_rate)
			|-> SYSCLK_OUT_O != $past(SYSCLK_OUT_O);
	endproperty
	a_half_rate: assert property (p_half_rate)
		else $error("half-rate clock output did not toggle");

	property p_layout_wr;
		wr_commit && wr_idx == dmcr_pkg::IDX_FMT
			|=> AUDIO_WORD_LAYOUT_O == $past(word[2:0]);
	endproperty
	a_layout_wr: assert property (p_layout_wr)
		else $error("layout field not taken from write");

	property p_deemph_or;
		wr_commit && wr_idx == dmcr_pkg::IDX_DEEMPH
			|=> DEEMPH_ENABLE_O == |$past(word[2:0]);
	endproperty
	a_deemph_or: assert property (p_deemph_or)
		else $error("de-emphasis enable not the or of three bits");

	property p_read_is_write;
		mc_rise && bit_cnt_ff == dmcr_pkg::CNT_LAST && word[dmcr_pkg::RW_BIT]
			|=> $stable(fmt_ff) && $stable(deemph_ff)
			&& $stable(readback_ff) && $stable(modgpio_ff);
	endproperty
	a_read_is_write: assert property (p_read_is_write)
		else $error("read word committed as a write");

	property p_single_read;
		rd_start && !inc |=> oe_ff && tx_ff == $past(rd_data)
			&& $past(rd_sel) == $past(read_index);
	endproperty
	a_single_read: assert property (p_single_read)
		else $error("single read returned wrong register");

	property p_auto_stop;
		rd_done_ff && inc && rd_start |=> !oe_ff;
	endproperty
	a_auto_stop: assert property (p_auto_stop)
		else $error("read continued past last index");

	property p_osr;
		CLK_RATIO_LOW_I && !over |-> OVERSAMPLE_RATIO_O == dmcr_pkg::OSR_32;
	endproperty
	a_osr: assert property (p_osr)
		else $error("low ratio default not 32x");

	property p_shared;
		wr_commit && wr_idx == dmcr_pkg::IDX_MODGPIO
			&& word[dmcr_pkg::USER_OUTPUT_ENABLE_POS]
			|=> SHARED_PIN_O
			== $past(word[dmcr_pkg::GPO_HI:dmcr_pkg::GPO_LO]);
	endproperty
	a_shared: assert property (p_shared)
		else $error("shared pins not driven from user bits");

	property p_flag_pins;
		!user_output_enable |-> SHARED_PIN_O == (det[5:0] ^ {6{flag_polarity}});
	endproperty
	a_flag_pins: assert property (p_flag_pins)
		else $error("shared pins not carrying channel flags");

	property p_zero_rise;
		$rose(det[0]) |-> $past(SAMPLE_TICK_I) && $past(CH_DATA_ZERO_I[0])
			&& $past(zcnt_ff[0]) == dmcr_pkg::ZERO_LIMIT - 11'h001;
	endproperty
	a_zero_rise: assert property (p_zero_rise)
		else $error("zero detect without full zero run");

	property p_all_flag;
		!flag_polarity && !(&det) |-> !SILENCE_FLAG_ALL_O;
	endproperty
	a_all_flag: assert property (p_all_flag)
		else $error("combined flag set without all channels");

	c_write:   cover property (wr_commit);
	c_read:    cover property (rd_start && !inc);
	c_auto:    cover property (rd_active && inc ##[1:200] rd_done_ff);
	c_all_zero: cover property ($rose(&det));

endmodule
